/* rtl/aex_expander.v */
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "aex_map.vh"

module aex_expander (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ser_clk,
  input  wire        access_enable_n,
  input  wire        serial_in,
  output wire        serial_out,
  input  wire [7:0]  address_strap,
  input  wire [7:0]  port_pins_in,
  output wire [7:0]  port_pins_out,
  output wire [7:0]  port_pins_oe,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready
);

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  // Only the low five strap bits are used; the upper three are spare.
  wire [15:0] sync_in;
  wire [15:0] sync_out;
  wire        sclk_s;
  wire        en_s;
  wire        sin_s;
  wire [7:0]  pins_s;
  wire [4:0]  strap_s;

  assign sync_in = {ser_clk, access_enable_n, serial_in, port_pins_in,
                    address_strap[`AEX_SY_STRAP_HI:`AEX_SY_STRAP_LO]};

  aex_sync #(
    .RST_VAL (`AEX_SYNC_RST)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (sync_in),
    .dout    (sync_out)
  );

  assign sclk_s  = sync_out[`AEX_SY_SCLK];
  assign en_s    = sync_out[`AEX_SY_EN];
  assign sin_s   = sync_out[`AEX_SY_SIN];
  assign pins_s  = sync_out[`AEX_SY_PIN_HI:`AEX_SY_PIN_LO];
  assign strap_s = sync_out[`AEX_SY_STRAP_HI:`AEX_SY_STRAP_LO];

  // --------------------------------------------------------------------------
  // Edge detection
  // --------------------------------------------------------------------------
  reg  sclk_d_reg;
  reg  en_d_reg;
  wire en_fall;
  wire en_rise;
  wire sclk_rise;
  wire sclk_fall;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_d_reg <= 1'b0;
      en_d_reg   <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      en_d_reg   <= en_s;
    end
  end

  assign en_fall   = en_d_reg & ~en_s;
  assign en_rise   = ~en_d_reg & en_s;
  // Serial clock edges count only inside an access; enable edges win.
  assign sclk_rise = sclk_s & ~sclk_d_reg & ~en_s & ~en_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg & ~en_s & ~en_d_reg;

  // --------------------------------------------------------------------------
  // Serial frame engine
  // --------------------------------------------------------------------------
  reg  [7:0]  cnt_reg;
  reg  [15:0] rx_reg;
  reg  [7:0]  tx_reg;
  reg         match_reg;
  reg         rd_mode_reg;
  reg         halt_reg;
  reg         active_reg;
  reg         sout_reg;
  reg  [7:0]  latch_reg;
  reg  [7:0]  oe_reg;
  reg  [7:0]  drive_reg;
  wire [15:0] rx_next;
  wire [7:0]  cnt_next;
  wire        clr_req;

  assign rx_next  = {rx_reg[14:0], sin_s};
  // The counter saturates so that a long access never wraps back to 16.
  assign cnt_next = (cnt_reg == `AEX_CNT_MAX) ? cnt_reg :
                    cnt_reg + `AEX_CNT_ONE;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg     <= `AEX_CNT_ZERO;
      rx_reg      <= `AEX_RX_RST;
      tx_reg      <= `AEX_TX_RST;
      match_reg   <= 1'b0;
      rd_mode_reg <= 1'b0;
      halt_reg    <= 1'b0;
      active_reg  <= 1'b0;
      sout_reg    <= 1'b1;
    end else if (en_fall) begin
      tx_reg      <= pins_s;
      cnt_reg     <= `AEX_CNT_ZERO;
      rx_reg      <= `AEX_RX_RST;
      match_reg   <= 1'b0;
      rd_mode_reg <= 1'b0;
      halt_reg    <= 1'b0;
      active_reg  <= 1'b1;
      sout_reg    <= 1'b1;
    end else if (en_rise) begin
      sout_reg    <= 1'b1;
      cnt_reg     <= `AEX_CNT_ZERO;
      active_reg  <= 1'b0;
      rd_mode_reg <= 1'b0;
    end else if (sclk_rise) begin
      rx_reg  <= rx_next;
      cnt_reg <= cnt_next;
      if (cnt_next == `AEX_CNT_ADDR) begin
        match_reg <= (rx_next[`AEX_STRAP_W-1:0] == strap_s);
      end
      if (cnt_next == `AEX_CNT_CMD && match_reg) begin
        if (rx_next[2:0] == `AEX_CMD_READ) begin
          rd_mode_reg <= 1'b1;
        end else begin
          halt_reg <= 1'b1;
        end
      end
      if (cnt_next == `AEX_CNT_RD_FIRST && halt_reg) begin
        sout_reg <= 1'b1;
      end
    end else if (sclk_fall) begin
      if (cnt_reg == `AEX_CNT_CMD && match_reg) begin
        sout_reg <= 1'b0;
      end else if (rd_mode_reg && cnt_reg >= `AEX_CNT_RD_FIRST &&
                   cnt_reg <= `AEX_CNT_FRAME) begin
        sout_reg <= tx_reg[7];
        tx_reg   <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // A mismatch never reaches either serial out branch, so it stays high.

  // --------------------------------------------------------------------------
  // Output latch and pin drivers
  // --------------------------------------------------------------------------
  // A frame load wins over a software clear arriving in the same cycle.
  always @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= `AEX_LATCH_RST;
      oe_reg    <= `AEX_OE_OFF;
      drive_reg <= `AEX_DRIVE_HIGH;
    end else begin
      drive_reg <= `AEX_DRIVE_HIGH;
      if (en_rise && cnt_reg == `AEX_CNT_FRAME && match_reg) begin
        latch_reg <= rx_reg[`AEX_PORT_W-1:0];
        oe_reg    <= ~rx_reg[`AEX_PORT_W-1:0];
      end else if (clr_req) begin
        latch_reg <= `AEX_LATCH_RST;
        oe_reg    <= `AEX_OE_OFF;
      end
    end
  end

  assign serial_out    = sout_reg;
  assign port_pins_out = drive_reg;
  assign port_pins_oe  = oe_reg;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  reg        awready_reg;
  reg        wready_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  reg        aw_got_reg;
  reg        w_got_reg;
  reg [7:0]  waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  reg        clr_reg;
  wire       aw_hs;
  wire       w_hs;
  wire       wr_do;
  wire       wr_ok;

  assign aw_hs   = s_axi_awvalid & awready_reg;
  assign w_hs    = s_axi_wvalid & wready_reg;
  assign wr_do   = aw_got_reg & w_got_reg & ~bvalid_reg;
  assign wr_ok   = ({waddr_reg[7:2], 2'b00} == `AEX_OFF_CTRL) ||
                   ({waddr_reg[7:2], 2'b00} == `AEX_OFF_LATCH) ||
                   ({waddr_reg[7:2], 2'b00} == `AEX_OFF_PORT) ||
                   ({waddr_reg[7:2], 2'b00} == `AEX_OFF_STATUS);
  assign clr_req = clr_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `AEX_RESP_OKAY;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      waddr_reg   <= 8'h00;
      wdata_reg   <= `AEX_ZERO_WORD;
      wstrb_reg   <= 4'h0;
      clr_reg     <= 1'b0;
    end else begin
      clr_reg <= 1'b0;
      if (!aw_got_reg && !bvalid_reg) begin
        awready_reg <= ~aw_hs;
      end
      if (!w_got_reg && !bvalid_reg) begin
        wready_reg <= ~w_hs;
      end
      if (aw_hs) begin
        aw_got_reg  <= 1'b1;
        waddr_reg   <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (w_hs) begin
        w_got_reg  <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? `AEX_RESP_OKAY : `AEX_RESP_SLVERR;
        if ({waddr_reg[7:2], 2'b00} == `AEX_OFF_CTRL && wstrb_reg[0]) begin
          clr_reg <= wdata_reg[`AEX_CTRL_CLR_BIT];
        end
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        aw_got_reg  <= 1'b0;
        w_got_reg   <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  reg        arready_reg;
  reg        rvalid_reg;
  reg [1:0]  rresp_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rd_word;
  reg        rd_ok;

  always @* begin
    rd_word = `AEX_ZERO_WORD;
    rd_ok   = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `AEX_OFF_CTRL: begin
        rd_word = `AEX_ZERO_WORD;
      end
      `AEX_OFF_LATCH: begin
        rd_word = {24'h00_0000, latch_reg};
      end
      `AEX_OFF_PORT: begin
        rd_word = {24'h00_0000, pins_s};
      end
      `AEX_OFF_STATUS: begin
        rd_word = {11'h000, strap_s, 4'h0, active_reg, halt_reg,
                   rd_mode_reg, match_reg, cnt_reg};
      end
      default: begin
        rd_word = `AEX_ZERO_WORD;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `AEX_RESP_OKAY;
      rdata_reg   <= `AEX_ZERO_WORD;
    end else begin
      if (!rvalid_reg) begin
        arready_reg <= 1'b1;
      end
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rd_word;
        rresp_reg   <= rd_ok ? `AEX_RESP_OKAY : `AEX_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

endmodule // aex_expander

/* pkg/aex_map.vh */
`ifndef AEX_MAP_VH
`define AEX_MAP_VH

// ----------------------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------------------
`define AEX_AXI_AW        8
`define AEX_OFF_CTRL      8'h00
`define AEX_OFF_LATCH     8'h04
`define AEX_OFF_PORT      8'h08
`define AEX_OFF_STATUS    8'h0C
`define AEX_RESP_OKAY     2'h0
`define AEX_RESP_SLVERR   2'h2
`define AEX_CTRL_CLR_BIT  0
`define AEX_ZERO_WORD     32'h0000_0000

// ----------------------------------------------------------------------------
// Frame layout and counts
// ----------------------------------------------------------------------------
`define AEX_PORT_W        8
`define AEX_STRAP_W       5
`define AEX_FRAME_W       16
`define AEX_CNT_W         8
`define AEX_CNT_ZERO      8'h00
`define AEX_CNT_ONE       8'h01
`define AEX_CNT_ADDR      8'h05
`define AEX_CNT_CMD       8'h08
`define AEX_CNT_RD_FIRST  8'h09
`define AEX_CNT_FRAME     8'h10
`define AEX_CNT_MAX       8'hFF
`define AEX_CMD_READ      3'h7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AEX_LATCH_RST     8'hFF
`define AEX_OE_OFF        8'h00
`define AEX_DRIVE_HIGH    8'hFF
`define AEX_TX_RST        8'h00
`define AEX_RX_RST        16'h0000

// ----------------------------------------------------------------------------
// Synchroniser vector: sclk 15, enable 14, serial in 13, pins 12:5, strap 4:0
// ----------------------------------------------------------------------------
`define AEX_SYNC_W        16
`define AEX_SYNC_RST      16'h4000
`define AEX_SY_SCLK       15
`define AEX_SY_EN         14
`define AEX_SY_SIN        13
`define AEX_SY_PIN_HI     12
`define AEX_SY_PIN_LO     5
`define AEX_SY_STRAP_HI   4
`define AEX_SY_STRAP_LO   0

`endif

/* rtl/aex_sync.v */
`timescale 1ns/1ps

// Three-stage synchroniser; a bit changes once stages two and three agree.
module aex_sync #(
  parameter [15:0] RST_VAL = 16'h0000
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [15:0] din,
  output wire [15:0] dout
);

  reg [15:0] s1_reg;
  reg [15:0] s2_reg;
  reg [15:0] s3_reg;
  reg [15:0] filt_reg;

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_bit
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1_reg[i]   <= RST_VAL[i];
          s2_reg[i]   <= RST_VAL[i];
          s3_reg[i]   <= RST_VAL[i];
          filt_reg[i] <= RST_VAL[i];
        end else begin
          s1_reg[i] <= din[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            filt_reg[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate

  assign dout = filt_reg;

endmodule // aex_sync

/* test/aex_expander_asserts.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module aex_chk (
  input wire       aclk,
  input wire       aresetn,
  input wire       ser_clk,
  input wire       access_enable_n,
  input wire       serial_out,
  input wire [7:0] port_pins_out,
  input wire [7:0] port_pins_oe,
  input wire       s_axi_bvalid
);
  reg [4:0] idle_reg;

  // A counter replaces a long repetition, which is slow to unroll.
  always @(posedge aclk) begin
    if (!aresetn || !access_enable_n || s_axi_bvalid) begin
      idle_reg <= 5'h00;
    end else if (idle_reg != 5'h1F) begin
      idle_reg <= idle_reg + 5'h01;
    end
  end

  default clocking dcb @(posedge aclk);
  endclocking

  AST_RESET_STATE: assert property (
    !aresetn |=> serial_out && port_pins_oe == 8'h00)
    else $error("reset state wrong");
  AST_RELEASE_STATE: assert property (
    disable iff (!aresetn) $rose(aresetn) |-> port_pins_oe == 8'h00)
    else $error("drivers on at reset release");
  AST_PIN_HIGH_ONLY: assert property (
    disable iff (!aresetn) port_pins_out == 8'hFF)
    else $error("pin drive level not high");
  AST_IDLE_OUT_HIGH: assert property (
    disable iff (!aresetn) idle_reg > 5'h0C |-> serial_out)
    else $error("serial out low while idle");
  AST_FALL_IN_ACCESS: assert property (
    disable iff (!aresetn) $fell(serial_out) |-> !access_enable_n)
    else $error("serial out fell outside access");
  AST_FALL_ON_CLK_FALL: assert property (
    disable iff (!aresetn)
    $fell(serial_out) |-> !ser_clk && $past(ser_clk, 7))
    else $error("serial out fell off a clock fall");
  AST_LATCH_HELD_ACCESS: assert property (
    disable iff (!aresetn)
    (!access_enable_n && !s_axi_bvalid)[*8] |-> $stable(port_pins_oe))
    else $error("pin drivers moved during access");
  AST_LATCH_HELD_IDLE: assert property (
    disable iff (!aresetn) idle_reg > 5'h0C |-> $stable(port_pins_oe))
    else $error("pin drivers moved while idle");
endmodule // aex_chk

bind aex_expander aex_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .ser_clk(ser_clk),
  .access_enable_n(access_enable_n), .serial_out(serial_out),
  .port_pins_out(port_pins_out), .port_pins_oe(port_pins_oe),
  .s_axi_bvalid(s_axi_bvalid)
);

/* test/aex_host.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Host end of the serial link
// ------------------------------------------------------------
module aex_host (
  output logic ser_clk,
  output logic access_enable_n,
  output logic serial_in,
  input  wire  serial_out
);
  logic [31:0] so_bits;

  // Clock idles low between frames; the data line rests at its pull-up.
  initial begin
    ser_clk = 1'h0;
    access_enable_n = 1'h1;
    serial_in = 1'h1;
    so_bits = 32'h0000_0000;
  end

  // Bit n of so_bits is the output level seen after clock fall n+1.
  task automatic xfer(input logic [15:0] w, input int n, input real h);
    so_bits = 32'h0000_0000;
    access_enable_n = 1'h0;
    for (int i = 1; i <= n; i++) begin
      serial_in = (i <= 16) ? w[16 - i] : 1'h1;
      #(h - 2.0);
      if (i > 1) so_bits[i - 2] = serial_out;
      #(2.0);
      ser_clk = 1'h1;
      #(h);
      ser_clk = 1'h0;
    end
    #(h - 2.0);
    so_bits[n - 1] = serial_out;
    #(2.0);
    serial_in = 1'h1;
    access_enable_n = 1'h1;
    #(4.0 * h);
  endtask

  // Clocks with the device deselected, only when a scenario asks.
  task automatic stray(input int n, input real h);
    for (int i = 0; i < n; i++) begin
      serial_in = i[0];
      #(h);
      ser_clk = 1'h1;
      #(h);
      ser_clk = 1'h0;
    end
    serial_in = 1'h1;
    #(4.0 * h);
  endtask
endmodule // aex_host

/* test/tb_top.sv */
`timescale 1ns/1ps
`include "aex_map.vh"

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module tb_top;
  localparam real H = 62.5;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  wire         ser_clk, access_enable_n, serial_in, serial_out;
  wire         awready, wready, bvalid, arready, rvalid;
  logic [7:0]  strap, ext_val, awaddr, araddr, latch_m;
  wire  [7:0]  pins_in, pins_oe, pins_out;
  logic [31:0] wdata, d;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  logic [1:0]  r;
  int          n_errors, n_tests;

  // Driven pins read high; the others follow the outside or pull down.
  assign pins_in = pins_oe | ext_val;

  aex_expander DUT (
    .aclk(aclk), .aresetn(aresetn), .ser_clk(ser_clk),
    .access_enable_n(access_enable_n), .serial_in(serial_in),
    .serial_out(serial_out), .address_strap(strap),
    .port_pins_in(pins_in), .port_pins_out(pins_out),
    .port_pins_oe(pins_oe), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  aex_host host (
    .ser_clk(ser_clk), .access_enable_n(access_enable_n),
    .serial_in(serial_in), .serial_out(serial_out)
  );

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic bound(inout int k);
    k++;
    if (k > 500) begin
      n_errors++;
      $display("CHECK FAILED handshake expected answer seen none");
      final_report();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      r = bresp;
      bound(k);
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      d = rdata;
      r = rresp;
      bound(k);
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
  endtask

  // The pin change after the fourth clock fall of the frame must not reach the readback.
  task automatic frame(input logic [4:0] a, input logic [2:0] c,
                       input logic [7:0] v, input int n, input real h,
                       input logic [7:0] late);
    logic [31:0] e;
    logic [7:0]  cap;
    logic        m;
    m = (a === strap[4:0]);
    cap = ~latch_m | ext_val;
    e = 32'h0000_0000;
    for (int i = 1; i <= n; i++) begin
      e[i - 1] = !m || i != 8;
      if (m && c == `AEX_CMD_READ && i > 8)
        e[i - 1] = cap[i > 16 ? 0 : 16 - i];
    end
    fork
      host.xfer({a, c, v}, n, h);
      begin
        #(8.0 * h);
        @(posedge aclk);
        ext_val <= late;
      end
    join
    if (m && n == 16) latch_m = v;
    repeat (10) @(posedge aclk);
    chk("serial out", e, host.so_bits);
    chk("pin enables", {24'h00_0000, ~latch_m}, {24'h00_0000, pins_oe});
  endtask

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  initial begin
    #(1_000_000);
    n_errors++;
    final_report();
  end

  initial begin
    aresetn = 1'h0;
    strap = 8'h15;
    ext_val = 8'h00;
    latch_m = 8'hFF;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    n_errors = 0;
    n_tests = 0;
    repeat (3) @(posedge aclk);
    chk("reset out", 32'h0000_0001, {31'h0, serial_out});
    chk("reset oe", 32'h0000_0000, {24'h00_0000, pins_oe});
    aresetn <= 1'h1;
    repeat (8) @(posedge aclk);
    axi_rd(`AEX_OFF_LATCH);
    chk("latch reg", 32'h0000_00FF, d);
    axi_rd(8'h10);
    chk("unmapped read", {30'h0, `AEX_RESP_SLVERR}, {30'h0, r});
    for (int c = 0; c < 7; c++)
      frame(5'h15, c[2:0], {c[2:0], 5'h15}, 16, H, 8'h44);
    frame(5'h15, `AEX_CMD_READ, 8'hFF, 16, H, 8'h00);
    frame(5'h15, 3'h2, 8'h81, 15, H, 8'h00);
    frame(5'h14, 3'h0, 8'h81, 16, H, 8'h00);
    frame(5'h15, 3'h0, 8'h0F, 16, 200.0, 8'h04);
    frame(5'h15, `AEX_CMD_READ, 8'h00, 17, H, 8'h00);
    host.stray(16, H);
    axi_rd(`AEX_OFF_STATUS);
    chk("idle count", 32'h0000_0000, {24'h00_0000, d[7:0]});
    frame(5'h15, 3'h0, 8'hAA, 16, H, 8'h00);
    axi_rd(`AEX_OFF_PORT);
    chk("pin levels", {24'h00_0000, ~latch_m | ext_val}, d);
    axi_wr(`AEX_OFF_CTRL, 32'h0000_0001);
    chk("ctrl resp", {30'h0, `AEX_RESP_OKAY}, {30'h0, r});
    repeat (6) @(posedge aclk);
    chk("cleared oe", 32'h0000_0000, {24'h00_0000, pins_oe});
    axi_rd(`AEX_OFF_LATCH);
    chk("cleared latch", 32'h0000_00FF, d);
    axi_wr(8'h20, 32'h0000_0001);
    chk("unmapped write", {30'h0, `AEX_RESP_SLVERR}, {30'h0, r});
    final_report();
  end
endmodule // tb_top
